//--- logic/dcwd_map.svh
// Constants for the door command word decoder: bit positions, codes,
// reset values. Definitions only; included by the package and modules.
`ifndef DCWD_MAP_SVH
`define DCWD_MAP_SVH

// Main control word bits
`define DCWD_CTL_ENABLE_BIT   3
`define DCWD_CTL_FAULT_ACK_BIT 7
`define DCWD_CTL_REMOTE_BIT   10
// Main status word bits
`define DCWD_STS_ENABLED_BIT  2
`define DCWD_STS_REMOTE_REQ_BIT 9
// Door command word fields
`define DCWD_CODE_LSB         0
`define DCWD_CODE_MSB         3
`define DCWD_MOD_SLOW_BIT     8
`define DCWD_MOD_NUDGE_BIT    9
`define DCWD_MOD_SPECIAL_BIT  11
`define DCWD_MOD_SYNC_BIT     13
`define DCWD_MOD_ENDPOS_BIT   14
`define DCWD_MOD_REVERSE_BIT  15
// Door command codes
`define DCWD_CODE_COAST       4'h0
`define DCWD_CODE_BRAKE       4'h1
`define DCWD_CODE_OPEN        4'h2
`define DCWD_CODE_CLOSE       4'h3
`define DCWD_CODE_LEARN       4'h4
`define DCWD_CODE_LAST_VALID  4'h4
// Reset values
`define DCWD_RST_CODE         4'h0
`define DCWD_RST_WORD         16'h0000

`endif

//--- logic/dcwd_pkg.sv
// Types shared by the door command word decoder files.
// Assumes dcwd_map.svh sits on the include path.
`include "dcwd_map.svh"

package dcwd_pkg;

   // Motor action driven out to the drive stage
   typedef enum logic [2:0]
   {
      DCWD_ACT_COAST = 3'h0,
      DCWD_ACT_BRAKE = 3'h1,
      DCWD_ACT_OPEN  = 3'h3,
      DCWD_ACT_CLOSE = 3'h2,
      DCWD_ACT_LEARN = 3'h6
   } dcwd_action_t;

   // Modifier flags qualifying the door command
   typedef struct packed
   {
      logic slow;
      logic nudge;
      logic special;
      logic wait_mode_sync_flag;
      logic end_position_sensor_flag;
      logic reversing_unit_flag;
   } dcwd_mods_t;

   // Decoded command as handed to motion control
   typedef struct packed
   {
      dcwd_action_t action;
      dcwd_mods_t   mods;
   } dcwd_cmd_t;

endpackage

//--- logic/dcwd_edge_det.sv
// Rising edge detector for one synchronous level.
// Assumes the input is already synchronous to sys_clk.
`timescale 1ns/10ps

module dcwd_edge_det
(
   input  wire logic sys_clk,   // Device clock
   input  wire logic resetn,    // Synchronous reset, active low
   input  wire logic level,     // Level to watch
   output logic      rise       // One-cycle pulse on 0 to 1
);
   logic prev_q;
   logic prev_d;

   // Previous level, cleared so a high level at release is an edge
   always_comb
   begin
      prev_d = level;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         prev_q <= 1'b0;
      else
         prev_q <= prev_d;
   end

   assign rise = level & ~prev_q;

endmodule

//--- logic/dcwd_decoder.sv
// Door command word decoder: takes the main control word and the door
// command word from cyclic process data and produces the motor action,
// modifier flags, fault-acknowledge pulse and remote-request status.
// Assumes both words are held stable by the fieldbus front end and are
// synchronous to sys_clk; new_frame pulses once per received frame.
`timescale 1ns/10ps
`include "dcwd_map.svh"

// Summary of operation
// - Remote grant bit 10 set makes received process data valid.
// - Grant bit clear: data ignored, local operation allowed.
// - Sign-of-life monitoring continues regardless of the grant bit.
// - Fault acknowledge bit 7 acts only on a rising edge.
// - Door command code is bits 0 to 3 of the door command word.
// - Reserved codes 5 to 15 are rejected; last valid code kept.
// - Code 0 de-energizes the motor so it coasts.
// - Code 1 brakes by shorting the winding.
// - Code 2 drives in the learned opening direction.
// - Code 3 drives in the learned closing direction.
// - Code 4 starts a learn run with the active parameter record.
// - Bits 8 to 15 are modifier flags qualifying the command; bits 10 and 12 are not decoded.
// - Modifier bit 8 selects the slow motion profile.
// - Modifier bit 9 selects nudging, when the feature is present.
// - Modifier bit 11 selects the special learn run variant.
// - Modifier bit 13 is the waiting mode sync flag.
// - Modifier bit 14 carries the end-position sensor indication.
// - Modifier bit 15 carries the reversing unit signal.
// - Remote commands execute only while enable-operation bit 3 is set; local commands always execute.
// - Status bit 9 set while remote takeover is requested.
module dcwd_decoder
#(
   parameter bit NUDGE_PRESENT = 1'b1   // Nudging feature built in
)
(
   input  wire logic             sys_clk,           // 125 MHz clock
   input  wire logic             resetn,            // Sync reset, low
   input  wire logic [15:0]      main_control_word, // Received control
   input  wire logic [15:0]      door_command_word, // Received command
   input  wire logic             new_frame,         // Frame received
   input  wire logic             remote_request,    // Takeover wanted
   input  wire logic             local_cmd_valid,   // Local cmd strobe
   input  wire dcwd_pkg::dcwd_cmd_t local_cmd,      // Local command
   output dcwd_pkg::dcwd_cmd_t   cmd_out,           // Applied command
   output logic                  cmd_execute,       // Motion enabled
   output logic                  remote_active,     // Data valid
   output logic                  fault_ack,         // Ack pulse
   output logic                  code_rejected,     // Reserved code seen
   output logic                  life_frame,        // Sign-of-life tick
   output logic [15:0]           main_status_word   // Status bits
);
   import dcwd_pkg::*;

   logic [3:0]   code_q;
   logic [3:0]   code_d;
   dcwd_mods_t   mods_q;
   dcwd_mods_t   mods_d;
   dcwd_cmd_t    cmd_q;
   dcwd_cmd_t    cmd_d;
   logic         exec_q;
   logic         exec_d;
   logic         remote_q;
   logic         remote_d;
   logic         rej_q;
   logic         rej_d;
   logic         life_q;
   logic         life_d;
   logic [15:0]  status_q;
   logic [15:0]  status_d;
   logic         ack_raw;
   logic         grant;
   logic [3:0]   rx_code;
   logic         rx_valid;
   dcwd_action_t remote_act;

   // Field extraction from the received words
   assign grant    = main_control_word[`DCWD_CTL_REMOTE_BIT];
   assign rx_code  =
      door_command_word[`DCWD_CODE_MSB:`DCWD_CODE_LSB];
   assign rx_valid = (rx_code <= `DCWD_CODE_LAST_VALID);

   // Edge detect on the fault acknowledge bit; a steady level is ignored
   dcwd_edge_det u_ack_edge
   (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .level   (main_control_word[`DCWD_CTL_FAULT_ACK_BIT]),
      .rise    (ack_raw)
   );

   // Stored code and modifiers; only updated from valid remote data
   always_comb
   begin
      code_d = code_q;
      mods_d = mods_q;
      rej_d  = 1'b0;
      if (new_frame && grant)
      begin
         if (rx_valid)
            code_d = rx_code;
         else
            rej_d = 1'b1;
         // Only assigned bits are picked; 4..7, 10, 12 fall away
         // so unused bits can never disturb a command
         mods_d.slow    =
            door_command_word[`DCWD_MOD_SLOW_BIT];
         mods_d.nudge   = NUDGE_PRESENT &
            door_command_word[`DCWD_MOD_NUDGE_BIT];
         mods_d.special =
            door_command_word[`DCWD_MOD_SPECIAL_BIT];
         mods_d.wait_mode_sync_flag =
            door_command_word[`DCWD_MOD_SYNC_BIT];
         mods_d.end_position_sensor_flag =
            door_command_word[`DCWD_MOD_ENDPOS_BIT];
         mods_d.reversing_unit_flag =
            door_command_word[`DCWD_MOD_REVERSE_BIT];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         code_q <= `DCWD_RST_CODE;
         mods_q <= '0;
         rej_q  <= 1'b0;
      end
      else
      begin
         code_q <= code_d;
         mods_q <= mods_d;
         rej_q  <= rej_d;
      end
   end

   // Code to motor action; unknown codes cannot be stored, coast anyway
   always_comb
   begin
      case (code_q)
         `DCWD_CODE_COAST: remote_act = DCWD_ACT_COAST;
         `DCWD_CODE_BRAKE: remote_act = DCWD_ACT_BRAKE;
         `DCWD_CODE_OPEN:  remote_act = DCWD_ACT_OPEN;
         `DCWD_CODE_CLOSE: remote_act = DCWD_ACT_CLOSE;
         `DCWD_CODE_LEARN: remote_act = DCWD_ACT_LEARN;
         default:          remote_act = DCWD_ACT_COAST;
      endcase
   end

   // Command source select and execution gating
   always_comb
   begin
      cmd_d    = cmd_q;
      remote_d = grant;
      exec_d   = main_control_word[`DCWD_CTL_ENABLE_BIT] &
                 grant;
      if (grant)
      begin
         cmd_d.action = remote_act;
         cmd_d.mods   = mods_q;
      end
      else
      begin
         // Local panel drives the door when remote data is invalid
         exec_d = 1'b1;
         if (local_cmd_valid)
            cmd_d = local_cmd;
      end
      // Not executing means the motor is left coasting
      if (!exec_d)
         cmd_d.action = DCWD_ACT_COAST;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         cmd_q    <= '{action: DCWD_ACT_COAST, mods: '0};
         remote_q <= 1'b0;
         exec_q   <= 1'b0;
      end
      else
      begin
         cmd_q    <= cmd_d;
         remote_q <= remote_d;
         exec_q   <= exec_d;
      end
   end

   // Status word and sign-of-life tick; the tick ignores the grant bit
   always_comb
   begin
      life_d   = new_frame;
      status_d = '0;
      status_d[`DCWD_STS_REMOTE_REQ_BIT] = remote_request;
      status_d[`DCWD_STS_ENABLED_BIT]    = exec_q;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         life_q   <= 1'b0;
         status_q <= `DCWD_RST_WORD;
      end
      else
      begin
         life_q   <= life_d;
         status_q <= status_d;
      end
   end

   // Fault ack also needs remote control; local acks come by panel
   assign fault_ack        = ack_raw & grant;
   assign cmd_out          = cmd_q;
   assign cmd_execute      = exec_q;
   assign remote_active    = remote_q;
   assign code_rejected    = rej_q;
   assign life_frame       = life_q;
   assign main_status_word = status_q;

   // Checks next to the logic they guard, all on sys_clk

   // A reserved code leaves the stored code alone
   a_reject_keeps_code: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      new_frame && grant && rx_code > 4'h4 |=> code_q == $past(code_q))
      else $error("reserved code changed stored code");

   // Rejection is also reported for one cycle
   a_reject_flag: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      new_frame && grant && rx_code > 4'h4 |=> code_rejected)
      else $error("reserved code not flagged");

   // A valid code is stored from a granted frame
   a_valid_code_taken: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      new_frame && grant && rx_code <= 4'h4 |=> code_q == $past(rx_code))
      else $error("valid code not stored");

   // Without the grant nothing received is stored
   a_no_grant_hold: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !grant |=> code_q == $past(code_q) && mods_q == $past(mods_q))
      else $error("data taken without grant");

   // Without the grant the local command runs
   a_local_taken: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !grant && local_cmd_valid |=> cmd_execute &&
      cmd_out == $past(local_cmd))
      else $error("local command not applied");

   // An ack pulse needs a rising edge on the ack bit
   a_ack_edge_only: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      fault_ack |-> !$past(main_control_word[7]))
      else $error("ack without rising edge");

   // A granted rising edge always gives the pulse
   a_ack_rise: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      grant && main_control_word[7] && !$past(main_control_word[7])
      |-> fault_ack)
      else $error("rising ack edge missed");

   // Enable bit clear with the grant set: nothing moves
   a_enable_gates: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      grant && !main_control_word[3] |=> !cmd_execute &&
      cmd_out.action == DCWD_ACT_COAST)
      else $error("command executed while disabled");

   // Stored code to motor action, one check per valid code
   a_coast_decode: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      grant && main_control_word[3] && code_q == 4'h0 |=>
      cmd_out.action == DCWD_ACT_COAST)
      else $error("coast code not decoded");

   a_brake_decode: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      grant && main_control_word[3] && code_q == 4'h1 |=>
      cmd_out.action == DCWD_ACT_BRAKE)
      else $error("brake code not decoded");

   a_open_decode: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      grant && main_control_word[3] && code_q == 4'h2 |=>
      cmd_out.action == DCWD_ACT_OPEN)
      else $error("open code not decoded");

   a_close_decode: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      grant && main_control_word[3] && code_q == 4'h3 |=>
      cmd_out.action == DCWD_ACT_CLOSE)
      else $error("close code not decoded");

   a_learn_decode: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      grant && main_control_word[3] && code_q == 4'h4 |=>
      cmd_out.action == DCWD_ACT_LEARN)
      else $error("learn code not decoded");

   // Stored modifiers travel with the granted command
   a_mods_passed: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      grant |=> cmd_out.mods == $past(mods_q))
      else $error("modifiers not passed on");

   // Slow flag reaches the command two cycles after its frame
   a_slow_flag: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      new_frame && grant ##1 grant |=>
      cmd_out.mods.slow == $past(door_command_word[8], 2))
      else $error("slow flag mismatch");

   // Each assigned modifier bit lands in its own flag
   a_nudge_flag: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      new_frame && grant |=> mods_q.nudge ==
      (NUDGE_PRESENT && $past(door_command_word[9])))
      else $error("nudge flag mismatch");

   a_special_flag: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      new_frame && grant |=>
      mods_q.special == $past(door_command_word[11]))
      else $error("special flag mismatch");

   a_sync_flag: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      new_frame && grant |=>
      mods_q.wait_mode_sync_flag == $past(door_command_word[13]))
      else $error("sync flag mismatch");

   a_end_pos_flag: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      new_frame && grant |=>
      mods_q.end_position_sensor_flag == $past(door_command_word[14]))
      else $error("end position flag mismatch");

   a_reverse_flag: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      new_frame && grant |=>
      mods_q.reversing_unit_flag == $past(door_command_word[15]))
      else $error("reversing flag mismatch");

   // Sign of life follows every frame, granted or not
   a_life_tick: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      new_frame |=> life_frame)
      else $error("sign of life lost");

   // Takeover request shows in the status word
   a_status_req: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      remote_request |=> main_status_word[9])
      else $error("remote request not shown");

endmodule

//--- verification/dcwd_plc_model.sv
// Supervisory controller stand-in that sends cyclic frames to the decoder.
// Assumes the bench calls send_frame and set_ctl from its main process.
`timescale 1ns/10ps

module dcwd_plc_model
(
   input  wire logic        sys_clk,           // Device clock
   input  wire logic        resetn,            // Sync reset, low
   input  wire logic [15:0] main_status_word,  // Device status
   output logic [15:0]      main_control_word, // Control word out
   output logic [15:0]      door_command_word, // Command word out
   output logic             new_frame          // Frame strobe
);
   logic req_seen_q;   // Takeover request observed

   // Front end starts idle, words held between frames
   initial
   begin
      main_control_word = 16'h0000;
      door_command_word = 16'h0000;
      new_frame = 1'b0;
   end

   // Grant only after the device has asked for it
   always @(posedge sys_clk)
      req_seen_q <= resetn & (req_seen_q | main_status_word[9]);

   // Control word change without a frame, grant masked
   task automatic set_ctl(input logic [15:0] ctl);
      @(negedge sys_clk);
      main_control_word = {ctl[15:11], ctl[10] & req_seen_q,
                           ctl[9:0]};
   endtask

   // One frame: words stay put afterwards, strobe lasts one cycle
   task automatic send_frame(input logic [15:0] ctl, input logic [15:0] cmd);
      set_ctl(ctl);
      door_command_word = cmd;
      new_frame = 1'b1;
      @(negedge sys_clk);
      new_frame = 1'b0;
   endtask
endmodule

//--- verification/door_command_word_decoder_tb.sv
// Self-checking bench for the door command word decoder.
// Assumes the logic/ files and the controller model are compiled first.
`timescale 1ns/10ps

module door_command_word_decoder_tb;
   import dcwd_pkg::*;

   typedef struct packed
   {
      logic [15:0]  word;
      dcwd_action_t act;
      logic         rej;
   } dcwd_row_t;

   logic              sys_clk = 1'b0;
   logic              resetn = 1'b0;
   logic              remote_request = 1'b0;
   logic              local_cmd_valid = 1'b0;
   dcwd_cmd_t         local_cmd = '0;
   logic [15:0]       main_control_word, door_command_word, main_status_word;
   logic              new_frame, cmd_execute, remote_active;
   logic              fault_ack, code_rejected, life_frame;
   dcwd_cmd_t         cmd_out;
   int                miscompares = 0;
   int                check_count = 0;
   dcwd_row_t         rows [8] = '{
      '{16'h0f00, DCWD_ACT_COAST, 1'b0},
      '{16'h10f1, DCWD_ACT_BRAKE, 1'b0},
      '{16'h2102, DCWD_ACT_OPEN,  1'b0},
      '{16'h4203, DCWD_ACT_CLOSE, 1'b0},
      '{16'h8804, DCWD_ACT_LEARN, 1'b0},
      '{16'h0402, DCWD_ACT_OPEN,  1'b0},
      '{16'he005, DCWD_ACT_OPEN,  1'b1},
      '{16'h000f, DCWD_ACT_OPEN,  1'b1}
   };

   // 125 MHz clock
   always #4 sys_clk = ~sys_clk;

   dcwd_decoder uut
   (
      .sys_clk(sys_clk), .resetn(resetn),
      .main_control_word(main_control_word),
      .door_command_word(door_command_word), .new_frame(new_frame),
      .remote_request(remote_request), .local_cmd_valid(local_cmd_valid),
      .local_cmd(local_cmd), .cmd_out(cmd_out), .cmd_execute(cmd_execute),
      .remote_active(remote_active), .fault_ack(fault_ack),
      .code_rejected(code_rejected), .life_frame(life_frame),
      .main_status_word(main_status_word)
   );

   dcwd_plc_model plc
   (
      .sys_clk(sys_clk), .resetn(resetn),
      .main_status_word(main_status_word),
      .main_control_word(main_control_word),
      .door_command_word(door_command_word), .new_frame(new_frame)
   );

   // Modifier flags as the command word should map them
   function automatic dcwd_mods_t mods_of(input logic [15:0] w);
      return {w[8], w[9], w[11], w[13], w[14], w[15]};
   endfunction

   task automatic chk(input string name, input logic [15:0] got, exp);
      check_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic report_and_stop;
      if (miscompares == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Whole run is a few dozen cycles; this is far beyond it
   initial
   begin
      #20000;
      miscompares++;
      report_and_stop();
   end

   // Main sequence: reset, table, then the awkward cases
   initial
   begin
      repeat (5) @(negedge sys_clk);
      chk("reset outs", 16'({cmd_out, cmd_execute, remote_active,
          code_rejected, life_frame, fault_ack}), 16'h0000);
      chk("reset status", main_status_word, 16'h0000);
      resetn = 1'b1;
      remote_request = 1'b1;
      repeat (2) @(negedge sys_clk);
      // Local operation already runs before the grant, so bit 2 is set
      chk("status req", main_status_word, 16'h0204);
      foreach (rows[i])
      begin
         plc.send_frame(16'h0408, rows[i].word);
         chk("life", 16'(life_frame), 16'h0001);
         chk("rejected", 16'(code_rejected), 16'(rows[i].rej));
         @(negedge sys_clk);
         chk("cmd", 16'(cmd_out), 16'({rows[i].act,
             mods_of(rows[i].word)}));
         chk("execute", 16'(cmd_execute), 16'h0001);
         chk("remote", 16'(remote_active), 16'h0001);
      end
      @(negedge sys_clk);
      chk("status run", main_status_word, 16'h0204);
      // Enable bit dropped: no motion whatever the code
      plc.send_frame(16'h0400, 16'h0003);
      @(negedge sys_clk);
      chk("no enable", 16'({cmd_out.action, cmd_execute}),
          16'({DCWD_ACT_COAST, 1'b0}));
      // Ack acts on the rising edge only, not the level
      plc.set_ctl(16'h0488);
      #1 chk("ack rise", 16'(fault_ack), 16'h0001);
      @(negedge sys_clk);
      chk("ack level", 16'(fault_ack), 16'h0000);
      plc.set_ctl(16'h0408);
      #1 chk("ack fall", 16'(fault_ack), 16'h0000);
      // Grant withdrawn: frames ignored, local command runs
      local_cmd = {DCWD_ACT_BRAKE, 6'h05};
      local_cmd_valid = 1'b1;
      plc.send_frame(16'h0008, 16'h0009);
      local_cmd_valid = 1'b0;
      chk("life local", 16'(life_frame), 16'h0001);
      chk("rej local", 16'(code_rejected), 16'h0000);
      repeat (2) @(negedge sys_clk);
      chk("local cmd", 16'({cmd_out, cmd_execute, remote_active}),
          16'({DCWD_ACT_BRAKE, 6'h05, 1'b1, 1'b0}));
      // Reset in mid-run clears everything, then local operation resumes
      resetn = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk("mid reset", 16'({cmd_out, cmd_execute, remote_active,
          code_rejected, life_frame, fault_ack}), 16'h0000);
      chk("mid status", main_status_word, 16'h0000);
      resetn = 1'b1;
      repeat (2) @(negedge sys_clk);
      chk("status again", main_status_word, 16'h0204);
      chk("local again", 16'({cmd_out, cmd_execute}),
          16'({DCWD_ACT_COAST, 6'h00, 1'b1}));
      report_and_stop();
   end
endmodule
